// ---- hdl/ssp_defs.vh ----
// constants shared by the sensor serial slave port
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH
`define SSP_DEV_ADDR      7'h35 // arbitrary strap value
`define SSP_ARA_ADDR      7'h0C
`define SSP_TIMEOUT_MS    30
`define SSP_CLK_MHZ       125
`define SSP_TIMEOUT_CYC   (`SSP_TIMEOUT_MS * `SSP_CLK_MHZ * 1000)
`define SSP_REG_AW        8
`define SSP_REG_DW        8
`endif

// ---- hdl/ssp_reg_mem.v ----
// register memory of the sensor serial slave port
`timescale 1ns/1ps
`default_nettype none
module ssp_reg_mem #(
    parameter AW = 8,
    parameter DW = 8
) (
    input  wire          clock,   // system clock
    input  wire          wr_en,   // write strobe
    input  wire [AW-1:0] wr_addr, // write address
    input  wire [DW-1:0] wr_data, // write data
    input  wire [AW-1:0] rd_addr, // read address
    output reg  [DW-1:0] rd_data  // registered read data
);
    reg [DW-1:0] mem [0:(1<<AW)-1];
    always @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// ---- hdl/ssp_slave.v ----
// smbus slave port of a temperature sensor
// Operation
// - write byte: address, pointer, data, all acked
// - read byte: pointer, restart, read, one byte
// - send byte loads pointer only
// - receive byte returns pointed register, no advance
// - alert response returns own address when alerting
// - alert response completes only without arbitration loss
// - completed alert response sets mask bit
// - alert response leaves status untouched
// - respond only to fixed hardware address and, while alerting, to the alert response address
// - clock low past timeout resets protocol
// - timeout enable clear disables timeout
// - port works fully in standby
// - foreign address gets no ack, no change
// - follow clock stretched by others
`timescale 1ns/1ps
`default_nettype none
`include "ssp_defs.vh"
module ssp_slave #(
    parameter [6:0] DEV_ADDR    = `SSP_DEV_ADDR,    // address strap, arbitrary default
    parameter       TIMEOUT_CYC = `SSP_TIMEOUT_CYC  // clock low timeout in cycles
) (
    input  wire       clock,            // 125 MHz system clock
    input  wire       arst_n,           // async active low reset
    input  wire       serial_bus_clock, // bus clock pin
    input  wire       sda_in,           // bus data pin level
    output wire       sda_out,          // data drive value (always 0)
    output reg        sda_oe_reg,       // data pull low enable
    input  wire       timeout_en,       // timeout enable bit
    input  wire       alert_pending,    // alert condition active
    output reg        alert_mask_set,   // pulse: set alert mask bit
    input  wire       standby           // low power state
);
    localparam ST_IDLE = 3'd0;
    localparam ST_ADDR = 3'd1;
    localparam ST_AACK = 3'd2;
    localparam ST_RXB  = 3'd3;
    localparam ST_RACK = 3'd4;
    localparam ST_TXB  = 3'd5;
    localparam ST_TACK = 3'd6;
    // ************************************************************
    // pin synchronisers and edge detect
    // ************************************************************
    reg [1:0] scl_sync_reg;
    reg [1:0] sda_sync_reg;
    reg       scl_d_reg;
    reg       sda_d_reg;
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            scl_sync_reg <= 2'b11;
            sda_sync_reg <= 2'b11;
            scl_d_reg    <= 1'b1;
            sda_d_reg    <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], serial_bus_clock};
            sda_sync_reg <= {sda_sync_reg[0], sda_in};
            scl_d_reg    <= scl_sync_reg[1];
            sda_d_reg    <= sda_sync_reg[1];
        end
    end
    wire scl   = scl_sync_reg[1];
    wire sda   = sda_sync_reg[1];
    // edges are taken from the bus itself, so stretching by others is followed
    wire scl_r = scl & ~scl_d_reg;
    wire scl_f = ~scl & scl_d_reg;
    wire start = scl & scl_d_reg & ~sda & sda_d_reg;
    wire stop  = scl & scl_d_reg & sda & ~sda_d_reg;
    // ************************************************************
    // timeout counter
    // ************************************************************
    reg [31:0] to_cnt_reg;
    wire       to_hit = timeout_en && (to_cnt_reg >= TIMEOUT_CYC);
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            to_cnt_reg <= 32'h0000_0000;
        end else if (scl || !timeout_en) begin
            to_cnt_reg <= 32'h0000_0000;
        end else if (!to_hit) begin
            to_cnt_reg <= to_cnt_reg + 32'h0000_0001;
        end
    end
    // ************************************************************
    // protocol engine
    // ************************************************************
    reg [2:0] state_reg;
    reg [3:0] bit_cnt_reg;   // counts rises, 8 ends a byte
    reg [7:0] shift_reg;
    reg       is_ara_reg;
    reg       is_read_reg;
    reg       byte_idx_reg;   // 0: pointer byte next, 1: data byte next
    reg       ara_ok_reg;
    reg       ack_pend_reg;
    reg [7:0] ptr_reg;
    reg [7:0] wdata_reg;
    reg       wr_pend_reg;
    wire [7:0] rd_data;
    wire [7:0] ara_byte = {DEV_ADDR, 1'b1};
    // standby is deliberately not used: the port runs regardless
    wire       unused_ok = standby;
    ssp_reg_mem #(
        .AW (`SSP_REG_AW),
        .DW (`SSP_REG_DW)
    ) u_mem (
        .clock   (clock),
        .wr_en   (wr_pend_reg),
        .wr_addr (ptr_reg),
        .wr_data (wdata_reg),
        .rd_addr (ptr_reg),
        .rd_data (rd_data)
    );
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_reg      <= ST_IDLE;
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= 8'h00;
            is_ara_reg     <= 1'b0;
            is_read_reg    <= 1'b0;
            byte_idx_reg   <= 1'b0;
            ara_ok_reg     <= 1'b0;
            ack_pend_reg   <= 1'b0;
            ptr_reg        <= 8'h00;
            wdata_reg      <= 8'h00;
            wr_pend_reg    <= 1'b0;
            sda_oe_reg     <= 1'b0;
            alert_mask_set <= 1'b0;
        end else begin
            wr_pend_reg    <= 1'b0;
            alert_mask_set <= 1'b0;
            if (to_hit) begin
                state_reg  <= ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else if (start) begin
                state_reg    <= ST_ADDR;
                bit_cnt_reg  <= 4'h0;
                byte_idx_reg <= 1'b0;
                sda_oe_reg   <= 1'b0;
            end else if (stop) begin
                state_reg  <= ST_IDLE;
                sda_oe_reg <= 1'b0;
            end else begin
                case (state_reg)
                    ST_ADDR: begin
                        if (scl_r) begin
                            shift_reg   <= {shift_reg[6:0], sda};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        // the fall that closes a start has no bits behind it
                        if (scl_f && bit_cnt_reg == 4'h8) begin
                            is_read_reg <= shift_reg[0];
                            is_ara_reg  <= shift_reg[7:1] == `SSP_ARA_ADDR;
                            if ((shift_reg[7:1] == DEV_ADDR) ||
                                (shift_reg[7:1] == `SSP_ARA_ADDR && shift_reg[0] &&
                                 alert_pending)) begin
                                sda_oe_reg <= 1'b1;
                                state_reg  <= ST_AACK;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (scl_f) begin
                            bit_cnt_reg <= 4'h0;
                            if (is_read_reg) begin
                                // memory reads at the held pointer
                                shift_reg  <= is_ara_reg ? ara_byte : rd_data;
                                sda_oe_reg <= is_ara_reg ? ~ara_byte[7] : ~rd_data[7];
                                ara_ok_reg <= 1'b1;
                                state_reg  <= ST_TXB;
                            end else begin
                                sda_oe_reg <= 1'b0;
                                state_reg  <= ST_RXB;
                            end
                        end
                    end
                    ST_RXB: begin
                        if (scl_r) begin
                            shift_reg   <= {shift_reg[6:0], sda};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (scl_f && bit_cnt_reg == 4'h8) begin
                            sda_oe_reg   <= 1'b1;
                            ack_pend_reg <= 1'b1;
                            state_reg    <= ST_RACK;
                        end
                    end
                    ST_RACK: begin
                        if (scl_f) begin
                            sda_oe_reg   <= 1'b0;
                            ack_pend_reg <= 1'b0;
                            byte_idx_reg <= 1'b1;
                            if (!byte_idx_reg) begin
                                ptr_reg <= shift_reg;
                                bit_cnt_reg <= 4'h0;
                                state_reg <= ST_RXB;
                            end else begin
                                wdata_reg   <= shift_reg;
                                wr_pend_reg <= 1'b1;
                                state_reg   <= ST_IDLE;
                            end
                        end
                    end
                    ST_TXB: begin
                        if (scl_r) begin
                            // drove 1 but saw 0: lost arbitration
                            if (!sda_oe_reg && !sda) begin
                                ara_ok_reg <= 1'b0;
                                sda_oe_reg <= 1'b0;
                                state_reg  <= ST_IDLE;
                            end
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (scl_f) begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            if (bit_cnt_reg == 4'h8) begin
                                sda_oe_reg <= 1'b0;
                                state_reg  <= ST_TACK;
                            end else begin
                                sda_oe_reg <= ~shift_reg[6];
                            end
                        end
                    end
                    ST_TACK: begin
                        if (scl_r) begin
                            // status is never touched here, only mask
                            alert_mask_set <= is_ara_reg && ara_ok_reg;
                            state_reg      <= ST_IDLE;
                        end
                    end
                    default: begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end
    assign sda_out = 1'b0;
endmodule
`default_nettype wire

// ---- test/ssp_assertions.sv ----
// assertion checker of the sensor serial slave port
`timescale 1ns/1ps
`default_nettype none
module ssp_assertions #(
    parameter [6:0] DEV_ADDR    = 7'h35, // own address, arbitrary
    parameter       TIMEOUT_CYC = 2000   // clock low limit
) (
    input wire logic clock,            // clock
    input wire logic arst_n,           // reset
    input wire logic serial_bus_clock, // bus clock
    input wire logic sda_in,           // data level
    input wire logic sda_out,          // drive value
    input wire logic sda_oe_reg,       // pull low
    input wire logic timeout_en,       // timeout on
    input wire logic alert_pending,    // alert
    input wire logic alert_mask_set,   // mask pulse
    input wire logic standby           // standby
);
    int lo_n;
    int hi_n;
    int drv_age;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    // ****************************************
    // bus clock low/high spans, age of last drive
    // ****************************************
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            lo_n    <= 0;
            hi_n    <= 0;
            drv_age <= 0;
        end else begin
            lo_n    <= serial_bus_clock ? 0 : lo_n + 1;
            hi_n    <= serial_bus_clock ? hi_n + 1 : 0;
            drv_age <= sda_oe_reg ? 0 : drv_age + 1;
        end
    end
    sequence s_pulse;
        alert_mask_set ##1 !alert_mask_set;
    endsequence
    sequence s_hold;
        sda_oe_reg [*4];
    endsequence
    AST_DRIVE_IN_LOW: assert property ($rose(sda_oe_reg) |-> !serial_bus_clock)
        else $error("data drive began with bus clock high");
    AST_DRIVE_HELD: assert property ($rose(sda_oe_reg) |-> s_hold)
        else $error("data drive not held");
    AST_TIMEOUT: assert property (timeout_en && lo_n == TIMEOUT_CYC + 16 |-> !sda_oe_reg)
        else $error("data still driven after clock low timeout");
    AST_NO_TIMEOUT: assert property (!timeout_en && lo_n > 8 |-> $stable(sda_oe_reg))
        else $error("data drive changed in long clock low");
    AST_IDLE_QUIET: assert property (hi_n > 6 |-> !sda_oe_reg)
        else $error("data driven on idle bus");
    AST_MASK_PULSE: assert property (alert_mask_set |-> s_pulse)
        else $error("mask pulse longer than one cycle");
    AST_MASK_ALERT: assert property (alert_mask_set |-> alert_pending)
        else $error("mask set without alert");
    AST_MASK_AFTER_SEND: assert property (alert_mask_set |-> !sda_oe_reg && drv_age < 48)
        else $error("mask set without address sent");
endmodule
bind ssp_slave ssp_assertions #(.DEV_ADDR(DEV_ADDR), .TIMEOUT_CYC(TIMEOUT_CYC)) ssp_assertions_inst (
    .clock(clock), .arst_n(arst_n), .serial_bus_clock(serial_bus_clock), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_reg(sda_oe_reg), .timeout_en(timeout_en),
    .alert_pending(alert_pending), .alert_mask_set(alert_mask_set), .standby(standby));
`default_nettype wire

// ---- test/ssp_host.sv ----
// smbus host model driving bus clock and data
`timescale 1ns/1ps
`default_nettype none
module ssp_host (
    output logic      scl, // bus clock
    output logic      sdo, // data drive, 1 released
    input  wire logic sda  // data wire level
);
    initial begin
        scl = 1'b1;
        sdo = 1'b1;
    end
    // every step is whole clock periods, so the bus moves just after a clock edge
    task automatic bit_io(input logic b, output logic r);
        #16 sdo = b;
        #24 scl = 1'b1;
        r = sda;
        #24 scl = 1'b0;
    endtask
    task automatic start;
        #16 sdo = 1'b1;
        #24 scl = 1'b1;
        #40 sdo = 1'b0;
        #40 scl = 1'b0;
    endtask
    task automatic stop;
        #16 sdo = 1'b0;
        #24 scl = 1'b1;
        #40 sdo = 1'b1;
        #40;
    endtask
    // msb first byte, then ack bit; last=1 is the nack of a read
    task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx,
                        output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(last, ack);
    endtask
endmodule
`default_nettype wire

// ---- test/ssp_slave_tb.sv ----
// testbench of the sensor serial slave port
`timescale 1ns/1ps
`default_nettype none
module ssp_slave_tb;
    localparam logic [6:0] DEV = 7'h2a;
    localparam logic [6:0] ARA = 7'h0c;
    localparam int         TMO = 2000;
    logic       clock = 1'b0;
    logic       arst_n = 1'b0;
    logic       timeout_en = 1'b0;
    logic       alert_pending = 1'b0;
    logic       standby = 1'b0;
    logic [7:0] rx;
    logic       ack;
    int         errors = 0;
    int         tests_run = 0;
    int         masks = 0;
    wire        scl, sdo, sda_out, sda_oe_reg, alert_mask_set;
    wire        sda = (sda_oe_reg === 1'b1) ? sda_out : sdo;
    always #4 clock = ~clock;
    always @(posedge clock) if (alert_mask_set === 1'b1) masks++;
    ssp_slave #(.DEV_ADDR(DEV), .TIMEOUT_CYC(TMO)) ssp_slave_inst (.clock(clock), .arst_n(arst_n),
        .serial_bus_clock(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_reg(sda_oe_reg),
        .timeout_en(timeout_en), .alert_pending(alert_pending),
        .alert_mask_set(alert_mask_set), .standby(standby));
    ssp_host ssp_host_inst (.scl(scl), .sdo(sdo), .sda(sda));
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wb(input logic [7:0] tx, input logic exp_ack);
        ssp_host_inst.xfer(tx, 1'b1, rx, ack);
        check("ack", {7'h00, ack}, {7'h00, exp_ack});
    endtask
    task automatic receive(input logic [7:0] exp);
        ssp_host_inst.start;
        wb({DEV, 1'b1}, 1'b0);
        ssp_host_inst.xfer(8'hff, 1'b1, rx, ack);
        check("read data", rx, exp);
        ssp_host_inst.stop;
    endtask
    task automatic t_wr_rd;
        ssp_host_inst.start;
        wb({DEV, 1'b0}, 1'b0);
        wb(8'hff, 1'b0);
        wb(8'h3c, 1'b0);
        ssp_host_inst.stop;
        ssp_host_inst.start;
        wb({DEV, 1'b0}, 1'b0);
        wb(8'hff, 1'b0);
        receive(8'h3c);
    endtask
    task automatic t_send_recv;
        @(posedge clock) #1 standby = 1'b1;
        ssp_host_inst.start;
        wb({DEV, 1'b0}, 1'b0);
        wb(8'h10, 1'b0);
        wb(8'h5a, 1'b0);
        ssp_host_inst.stop;
        receive(8'h5a);
        ssp_host_inst.start;
        wb({DEV, 1'b0}, 1'b0);
        wb(8'hff, 1'b0);
        ssp_host_inst.stop;
        receive(8'h3c);
        receive(8'h3c);
    endtask
    task automatic t_refuse;
        ssp_host_inst.start;
        wb({DEV ^ 7'h01, 1'b0}, 1'b1);
        wb(8'hff, 1'b1);
        wb(8'h00, 1'b1);
        ssp_host_inst.stop;
        ssp_host_inst.start;
        wb({ARA, 1'b1}, 1'b1);
        ssp_host_inst.stop;
        receive(8'h3c);
    endtask
    task automatic t_alert;
        @(posedge clock) #1 alert_pending = 1'b1;
        ssp_host_inst.start;
        wb({ARA, 1'b1}, 1'b0);
        // another responder pulls every bit low: arbitration lost
        ssp_host_inst.xfer(8'h00, 1'b1, rx, ack);
        ssp_host_inst.stop;
        check("mask pulses", masks[7:0], 8'h00);
        ssp_host_inst.start;
        wb({ARA, 1'b1}, 1'b0);
        ssp_host_inst.xfer(8'hff, 1'b1, rx, ack);
        check("alert address", rx, {DEV, 1'b1});
        ssp_host_inst.stop;
        check("mask pulses", masks[7:0], 8'h01);
        @(posedge clock) #1 alert_pending = 1'b0;
    endtask
    task automatic t_timeout(input logic en);
        @(posedge clock) #1 timeout_en = en;
        ssp_host_inst.start;
        wb({DEV, 1'b1}, 1'b0);
        #(TMO * 8 + 400);
        check("held data line", {7'h00, sda}, {7'h00, en});
        repeat (8) ssp_host_inst.bit_io(1'b1, ack);
        ssp_host_inst.stop;
        receive(8'h3c);
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        #1 arst_n = 1'b1;
        repeat (8) @(posedge clock);
        #1;
        t_wr_rd;
        t_send_recv;
        t_refuse;
        t_alert;
        t_timeout(1'b0);
        t_timeout(1'b1);
        close_out;
    end
    initial begin
        #300000;
        errors++;
        close_out;
    end
endmodule
`default_nettype wire
